// *** pkg/rxctl_pkg.sv ***
// Constants for the per-channel receive control register bank.
// Assumes a host register port with byte-wide data and 8-bit addresses.
package rxctl_pkg;
  localparam int          RXCTL_CHANNELS   = 3;
  localparam logic [7:0]  RXCTL_ADDR_CH0   = 8'h05;
  localparam logic [7:0]  RXCTL_ADDR_CH1   = 8'h0D;
  localparam logic [7:0]  RXCTL_ADDR_CH2   = 8'h15;
  localparam int          RXCTL_BIT_DIG_DET = 5;
  localparam int          RXCTL_BIT_ANA_DET = 4;
  localparam int          RXCTL_BIT_EDGE   = 3;
  localparam int          RXCTL_BIT_MUTE   = 2;
  localparam int          RXCTL_BIT_MON    = 1;
  localparam int          RXCTL_BIT_EQ     = 0;
  localparam logic [7:0]  RXCTL_WR_MASK    = 8'h3F;
  localparam logic [7:0]  RXCTL_RESET      = 8'h00;
  localparam logic [1:0]  RXCTL_RATE_E3    = 2'h0;
  localparam logic [1:0]  RXCTL_RATE_DS3   = 2'h1;
  localparam logic [1:0]  RXCTL_RATE_STS1  = 2'h2;
endpackage : rxctl_pkg

// *** logic/rxctl_chan.sv ***
// One channel's receive control register and the controls derived from it.
// Assumes the write strobe and the line status inputs are on ref_clk.
`timescale 1ns/100ps
module rxctl_chan (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Register access
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] reg_value,
  // Channel status
  input  wire logic [1:0] rate_sel,
  input  wire logic       loss_of_signal,
  input  wire logic       rx_pos_in,
  input  wire logic       rx_neg_in,
  // Channel controls
  output logic            digital_loss_detector_en,
  output logic            analog_loss_detector_en,
  output logic            rx_clock_edge_select,
  output logic            recovered_positive_data,
  output logic            recovered_negative_data,
  output logic            monitor_mode_en,
  output logic            equalizer_en
);
  import rxctl_pkg::*;

  logic [7:0] ctl_r;
  logic [7:0] ctl_nxt;
  wire        is_e3 = (rate_sel == RXCTL_RATE_E3);
  wire        mute  = ctl_r[RXCTL_BIT_MUTE] & loss_of_signal;

  assign ctl_nxt = wr_en ? (wr_data & RXCTL_WR_MASK) : ctl_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_r <= RXCTL_RESET;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  assign reg_value                = ctl_r;
  // Disable bits count at every rate other than E3.
  assign digital_loss_detector_en = is_e3 | ~ctl_r[RXCTL_BIT_DIG_DET];
  assign analog_loss_detector_en  = is_e3 | ~ctl_r[RXCTL_BIT_ANA_DET];
  assign rx_clock_edge_select     = ctl_r[RXCTL_BIT_EDGE];
  assign monitor_mode_en          = ctl_r[RXCTL_BIT_MON];
  assign equalizer_en             = ctl_r[RXCTL_BIT_EQ];
  assign recovered_positive_data  = rx_pos_in & ~mute;
  assign recovered_negative_data  = rx_neg_in & ~mute;

  mute_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mute |-> !recovered_positive_data && !recovered_negative_data)
    else $error("data not muted during loss of signal");
  mute_pass_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !ctl_r[RXCTL_BIT_MUTE] |-> recovered_positive_data == rx_pos_in
                               && recovered_negative_data == rx_neg_in)
    else $error("data altered while muting off");
  e3_ignore_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    is_e3 |-> digital_loss_detector_en && analog_loss_detector_en)
    else $error("detector disabled in E3 mode");
  dig_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_en && wr_data[RXCTL_BIT_DIG_DET] ##1 !is_e3 |-> !digital_loss_detector_en)
    else $error("digital detector not switched off");
  ana_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_en && wr_data[RXCTL_BIT_ANA_DET] ##1 !is_e3 |-> !analog_loss_detector_en)
    else $error("analog detector not switched off");
  edge_sel_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_en |=> rx_clock_edge_select == $past(wr_data[RXCTL_BIT_EDGE]))
    else $error("edge select not written");
  mon_eq_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_en |=> monitor_mode_en == $past(wr_data[RXCTL_BIT_MON])
              && equalizer_en == $past(wr_data[RXCTL_BIT_EQ]))
    else $error("monitor or equalizer bit not written");
  readback_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_en |=> reg_value == ($past(wr_data) & RXCTL_WR_MASK))
    else $error("readback differs from write");
  hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !wr_en |=> $stable(reg_value))
    else $error("register changed without write");
  mute_c: cover property (@(posedge ref_clk) disable iff (!rst_n) mute);
  eq_on_c: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(equalizer_en));
  e3_dis_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    is_e3 && ctl_r[RXCTL_BIT_DIG_DET]);
endmodule : rxctl_chan

// *** logic/rxctl_bank.sv ***
// Receive control register bank for three line channels.
// Assumes a synchronous host port on ref_clk; line status arrives from other clocks.
`timescale 1ns/100ps

module rxctl_bank #(
  parameter int CHANNELS = rxctl_pkg::RXCTL_CHANNELS
) (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                arst_n,
  // Host register port
  input  wire logic                host_wr,
  input  wire logic                host_rd,
  input  wire logic [7:0]          host_addr,
  input  wire logic [7:0]          host_wdata,
  output logic      [7:0]          host_rdata,
  output logic                     host_hit,
  // Line status, asynchronous
  input  wire logic [CHANNELS-1:0] loss_of_signal,
  input  wire logic [2*CHANNELS-1:0] rate_sel,
  // Recovered data, on ref_clk
  input  wire logic [CHANNELS-1:0] rx_pos_in,
  input  wire logic [CHANNELS-1:0] rx_neg_in,
  // Channel controls
  output logic      [CHANNELS-1:0] digital_loss_detector_en,
  output logic      [CHANNELS-1:0] analog_loss_detector_en,
  output logic      [CHANNELS-1:0] rx_clock_edge_select,
  output logic      [CHANNELS-1:0] recovered_positive_data,
  output logic      [CHANNELS-1:0] recovered_negative_data,
  output logic      [CHANNELS-1:0] monitor_mode_en,
  output logic      [CHANNELS-1:0] equalizer_en
);
  import rxctl_pkg::*;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_sync_r;
  wire        rst_n = rst_sync_r[1];

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  // ----------------------------------------
  // Status synchronisers
  // ----------------------------------------
  // Both stages together; only the second stage is read downstream.
  logic [CHANNELS-1:0]   sig_loss_s1_r, sig_loss_s2_r;
  logic [2*CHANNELS-1:0] rate_s1_r, rate_s2_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sig_loss_s1_r <= '0;
      sig_loss_s2_r <= '0;
      rate_s1_r     <= '0;
      rate_s2_r     <= '0;
    end else begin
      sig_loss_s1_r <= loss_of_signal;
      sig_loss_s2_r <= sig_loss_s1_r;
      rate_s1_r <= rate_sel;
      rate_s2_r <= rate_s1_r;
    end
  end

  // ----------------------------------------
  // Address decode and channels
  // ----------------------------------------
  function automatic logic [7:0] chan_addr(input int idx);
    unique case (idx)
      0:       chan_addr = RXCTL_ADDR_CH0;
      1:       chan_addr = RXCTL_ADDR_CH1;
      default: chan_addr = RXCTL_ADDR_CH2;
    endcase
  endfunction : chan_addr

  logic [CHANNELS-1:0] sel;
  logic [7:0]          chan_val [CHANNELS];
  logic [7:0]          rdata_nxt;
  // One wire for any mapped address keeps the hit flag and its checks in step.
  wire                 any_sel = |sel;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      assign sel[g] = (host_addr == chan_addr(g));
      rxctl_chan u_chan (
        .ref_clk                  (ref_clk),
        .rst_n                    (rst_n),
        .wr_en                    (host_wr & sel[g]),
        .wr_data                  (host_wdata),
        .reg_value                (chan_val[g]),
        .rate_sel                 (rate_s2_r[2*g +: 2]),
        .loss_of_signal           (sig_loss_s2_r[g]),
        .rx_pos_in                (rx_pos_in[g]),
        .rx_neg_in                (rx_neg_in[g]),
        .digital_loss_detector_en (digital_loss_detector_en[g]),
        .analog_loss_detector_en  (analog_loss_detector_en[g]),
        .rx_clock_edge_select     (rx_clock_edge_select[g]),
        .recovered_positive_data  (recovered_positive_data[g]),
        .recovered_negative_data  (recovered_negative_data[g]),
        .monitor_mode_en          (monitor_mode_en[g]),
        .equalizer_en             (equalizer_en[g])
      );
      // Each copy answers to its own address only, so channels stay independent.
      read_chan_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        host_rd && sel[g] |=> host_rdata == $past(chan_val[g]))
        else $error("channel readback wrong");
      other_wr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        host_wr && !sel[g] |=> chan_val[g] == $past(chan_val[g]))
        else $error("write reached another channel");
      own_wr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        host_wr && sel[g] |=> chan_val[g] == ($past(host_wdata) & RXCTL_WR_MASK))
        else $error("write did not land");
      // The synchronised rate is what the channel sees, so E3 must win there.
      e3_chan_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rate_s2_r[2*g +: 2] == RXCTL_RATE_E3
        |-> digital_loss_detector_en[g] && analog_loss_detector_en[g])
        else $error("detector off at E3 rate");
    end
  endgenerate

  always_comb begin
    rdata_nxt = 8'h00;
    for (int i = 0; i < CHANNELS; i++) begin
      if (sel[i]) begin
        rdata_nxt = chan_val[i];
      end
    end
  end

  // Read data is registered and answers one cycle after host_rd.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_rdata <= 8'h00;
      host_hit   <= 1'b0;
    end else begin
      host_rdata <= host_rd ? rdata_nxt : 8'h00;
      host_hit   <= host_rd & any_sel;
    end
  end

  // ----------------------------------------
  // Checks on reset release
  // ----------------------------------------
  // Reset must reach every channel as soon as the pin goes low.
  rst_hold_a: assert property (@(posedge ref_clk)
    !arst_n |=> !rst_n)
    else $error("internal reset not applied");
  // Release waits for two clean edges, trading two cycles for a glitch-free exit.
  rst_delay_a: assert property (@(posedge ref_clk)
    $rose(rst_n) |-> $past(arst_n) && $past(arst_n, 2))
    else $error("internal reset released too early");
  // The synchronisers start from a known level so no stale status leaks out.
  sync_clear_a: assert property (@(posedge ref_clk)
    !rst_n |-> sig_loss_s2_r == '0 && rate_s2_r == '0)
    else $error("status synchronisers not cleared");
  reset_zero_a: assert property (@(posedge ref_clk)
    $rose(rst_n) |-> equalizer_en == '0 && monitor_mode_en == '0)
    else $error("controls not zero after reset");
  reset_det_a: assert property (@(posedge ref_clk)
    $rose(rst_n) |-> digital_loss_detector_en == '1 && analog_loss_detector_en == '1
                     && rx_clock_edge_select == '0)
    else $error("detectors not running after reset");

  // ----------------------------------------
  // Checks on the status synchronisers
  // ----------------------------------------
  // Status takes exactly two edges to reach the channels. The first checks wait
  // three edges after reset so that no cleared stage is compared with live input.
  loss_sync_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    1'b1 ##3 1'b1 |-> sig_loss_s2_r == $past(loss_of_signal, 2))
    else $error("loss status delay wrong");
  rate_sync_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    1'b1 ##3 1'b1 |-> rate_s2_r == $past(rate_sel, 2))
    else $error("rate delay wrong");

  // ----------------------------------------
  // Checks on the host read port
  // ----------------------------------------
  // The port drives zero between answers so a shared read bus can OR the data.
  read_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !host_rd |=> host_rdata == 8'h00 && !host_hit)
    else $error("read port busy without a read");
  // A read that misses every channel is refused with zero data and no hit.
  read_miss_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    host_rd && !any_sel |=> host_rdata == 8'h00 && !host_hit)
    else $error("unmapped read answered");
  read_hit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    host_rd && any_sel |=> host_hit)
    else $error("mapped read not acknowledged");
  hit_rd_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    host_hit |-> $past(host_rd))
    else $error("hit without a read");
  read_map_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    host_rd && sel[0] |=> host_rdata == $past(chan_val[0]))
    else $error("channel 0 readback wrong");
  read_top_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    host_hit |-> host_rdata[7:6] == 2'h0)
    else $error("unused bits read as one");
  sel_onehot_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $onehot0(sel))
    else $error("address decodes to two channels");
  read_c: cover property (@(posedge ref_clk) disable iff (!rst_n) host_rd && sel[2]);
  miss_c: cover property (@(posedge ref_clk) disable iff (!rst_n) host_rd && !any_sel);
endmodule : rxctl_bank

// *** testbench/tb_top.sv ***
// Self-checking bench for the three-channel receive control register bank.
// Assumes reads answer one cycle after the strobe and line status is synced in two flops.
`timescale 1ns/100ps
module tb_top;
  import rxctl_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic        ref_clk    = 1'b0;
  logic        arst_n     = 1'b0;
  logic        host_wr    = 1'b0;
  logic        host_rd    = 1'b0;
  logic        ctl_req    = 1'b0;
  logic [7:0]  host_addr  = 8'h00;
  logic [7:0]  host_wdata = 8'h00;
  logic [2:0]  sig_loss   = 3'h0;
  logic [2:0]  pos_in     = 3'h0;
  logic [2:0]  neg_in     = 3'h0;
  logic [5:0]  rate       = 6'h00;
  logic [7:0]  host_rdata;
  logic        host_hit;
  logic [2:0]  dl_en, al_en, edge_sel, pos_out, neg_out, mon_en, eq_en;
  logic        rd_q       = 1'b0;
  logic        ctl_q      = 1'b0;
  logic [7:0]  regs [3];
  logic [20:0] notes [$];
  logic [20:0] seen;
  int          n_fail       = 0;
  int          total_checks = 0;
  int          cyc          = 0;

  always #5 ref_clk = ~ref_clk;

  rxctl_bank dut (.ref_clk(ref_clk), .arst_n(arst_n), .host_wr(host_wr), .host_rd(host_rd),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_hit(host_hit), .loss_of_signal(sig_loss), .rate_sel(rate), .rx_pos_in(pos_in),
    .rx_neg_in(neg_in), .digital_loss_detector_en(dl_en), .analog_loss_detector_en(al_en),
    .rx_clock_edge_select(edge_sel), .recovered_positive_data(pos_out),
    .recovered_negative_data(neg_out), .monitor_mode_en(mon_en), .equalizer_en(eq_en));

  // ----------------------------------------
  // Expectation model
  // ----------------------------------------
  function automatic logic [7:0] addr_of(input int c);
    return (c == 0) ? RXCTL_ADDR_CH0 : (c == 1) ? RXCTL_ADDR_CH1 : RXCTL_ADDR_CH2;
  endfunction : addr_of

  function automatic logic [20:0] exp_ctl();
    logic [20:0] v;
    logic        e3;
    logic        mute;
    v = '0;
    for (int c = 0; c < 3; c++) begin
      e3 = (rate[2*c +: 2] == RXCTL_RATE_E3);
      mute = regs[c][2] & sig_loss[c];
      v[7*c +: 7] = {e3 | ~regs[c][5], e3 | ~regs[c][4], regs[c][3], pos_in[c] & ~mute,
                     neg_in[c] & ~mute, regs[c][1], regs[c][0]};
    end
    return v;
  endfunction : exp_ctl

  // ----------------------------------------
  // Drivers: idle, wr, rd and chk each lower the strobes they do not raise, so back-to-back calls never leave two strobes high
  // ----------------------------------------
  task automatic idle();
    host_wr = 1'b0;
    host_rd = 1'b0;
    ctl_req = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : idle

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_rd = 1'b0;
    ctl_req = 1'b0;
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    for (int c = 0; c < 3; c++) if (a === addr_of(c)) regs[c] = d & RXCTL_WR_MASK;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic [20:0] n;
    n = '0;
    for (int c = 0; c < 3; c++) if (a === addr_of(c)) n = {12'h001, regs[c]};
    notes.push_back(n);
    host_wr = 1'b0;
    ctl_req = 1'b0;
    host_addr = a;
    host_rd = 1'b1;
    @(posedge ref_clk);
    #1;
  endtask : rd

  task automatic chk();
    notes.push_back(exp_ctl());
    host_wr = 1'b0;
    host_rd = 1'b0;
    ctl_req = 1'b1;
    @(posedge ref_clk);
    #1;
  endtask : chk

  task automatic do_reset();
    arst_n = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    for (int c = 0; c < 3; c++) regs[c] = RXCTL_RESET;
  endtask : do_reset

  task automatic test_done();
    if (notes.size() != 0) n_fail++;
    if (n_fail == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  // ----------------------------------------
  // Monitor: compares each answer with the oldest note
  // ----------------------------------------
  always @(posedge ref_clk) begin
    rd_q <= host_rd;
    ctl_q <= ctl_req;
    cyc <= cyc + 1;
  end

  always @(negedge ref_clk) begin
    if ((rd_q || ctl_q) && notes.size() == 0) begin
      n_fail++;
      $display("wrong value at %0t: answer with no note", $time);
    end
    if ((rd_q || ctl_q) && notes.size() > 0) begin
      seen = rd_q ? {12'h000, host_hit, host_rdata} : {dl_en[2], al_en[2], edge_sel[2],
        pos_out[2], neg_out[2], mon_en[2], eq_en[2], dl_en[1], al_en[1], edge_sel[1],
        pos_out[1], neg_out[1], mon_en[1], eq_en[1], dl_en[0], al_en[0], edge_sel[0],
        pos_out[0], neg_out[0], mon_en[0], eq_en[0]};
      total_checks++;
      if (seen !== notes[0]) begin
        n_fail++;
        $display("wrong value at %0t: got %h, expected %h", $time, seen, notes[0]);
      end
      void'(notes.pop_front());
    end
    // A hang is cut short here and counted as a mismatch.
    if (cyc > 20000) begin
      n_fail++;
      $display("wrong value at %0t: run timed out", $time);
      test_done();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h8B8E));
    do_reset();
    chk();
    for (int c = 0; c < 3; c++) rd(addr_of(c));
    wr(8'h0D, 8'hFF);
    wr(8'h06, 8'hFF);
    wr(8'h05, 8'hC0);
    for (int c = 0; c < 3; c++) rd(addr_of(c));
    rd(8'h06);
    idle();
    for (int i = 0; i < 40; i++) begin
      wr(addr_of($urandom_range(2)), 8'($urandom));
      for (int g = 0; g < 3; g++) rate[2*g +: 2] = 2'($urandom_range(2));
      sig_loss = 3'($urandom);
      pos_in = 3'($urandom);
      neg_in = 3'($urandom);
      repeat (3) idle();
      chk();
      rd(addr_of($urandom_range(2)));
      idle();
    end
    for (int c = 0; c < 3; c++) wr(addr_of(c), 8'h01);
    chk();
    idle();
    do_reset();
    chk();
    rd(8'h15);
    idle();
    idle();
    test_done();
  end
endmodule : tb_top
